// ===== hdl/pcs_top.sv
/*
 * Probe capture scope: circular capture buffers per probe, trigger
 * freeze, readout FIFO and an AHB-Lite register slave.
 * Assumes probe words synchronous to hclk and a single AHB-Lite master.
 */
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"

// ****************************************
// Readout FIFO
// ****************************************
module pcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    output logic [WIDTH-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg;
    logic [AW:0] rp_reg;
    logic push;
    logic pop;

    // Flags from pointer difference
    assign m_valid = (wp_reg != rp_reg);
    assign s_ready = ((wp_reg - rp_reg) != (AW+1)'(DEPTH));
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;
    assign m_data = mem[rp_reg[AW-1:0]];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg[AW-1:0]] <= s_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (clr) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end
endmodule

// ****************************************
// Top
// ****************************************
module pcs_top import pcs_pkg::*; #(
    parameter int NPROBE = 4,
    parameter int DEPTH = 16384,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NPROBE*16-1:0] probe_data,
    input wire logic [NPROBE-1:0] probe_valid,
    output logic [NPROBE-1:0] probe_frozen
);
    localparam int AW = $clog2(DEPTH);

    logic [15:0] mem [NPROBE][DEPTH];
    logic [31:0] ctrl_reg;
    logic [31:0] rdsel_reg;
    logic [31:0] cmd_reg;
    logic [31:0] pcfg_reg [NPROBE];
    logic [AW-1:0] wptr_reg [NPROBE];
    logic [14:0] dcnt_reg [NPROBE];
    logic [15:0] prev_reg [NPROBE];
    logic [NPROBE-1:0] armed_reg;
    logic [NPROBE-1:0] trig;
    logic [NPROBE-1:0] store;
    logic [7:0] waddr_reg;
    logic wr_pend_reg;
    logic [7:0] raddr_reg;
    logic rd_pend_reg;
    logic wr_now;
    logic [3:0] sw_trig;
    logic [3:0] sw_arm;
    logic ro_start;
    logic data_pop;
    pcs_ro_e ro_state_reg;
    logic [1:0] ro_sel_reg;
    logic [AW-1:0] ro_addr_reg;
    logic [AW:0] ro_left_reg;
    logic [15:0] ro_word_reg;
    logic ro_vld_reg;
    logic f_in_ready;
    logic [15:0] f_out_data;
    logic f_out_valid;

    // Register write strobes decoded in the data phase
    assign wr_now = wr_pend_reg;
    assign sw_trig = (wr_now && waddr_reg == `PCS_CMD_OFS) ?
        hwdata[`PCS_CMD_TRIG_LSB +: 4] : 4'h0;
    assign sw_arm = (wr_now && waddr_reg == `PCS_CMD_OFS) ?
        hwdata[`PCS_CMD_ARM_LSB +: 4] : 4'h0;
    assign ro_start = wr_now && waddr_reg == `PCS_RDSEL_OFS &&
        hwdata[`PCS_RDSEL_START_BIT] && ro_state_reg == PCS_RO_IDLE;
    assign data_pop = rd_pend_reg && raddr_reg == `PCS_DATA_OFS;

    // Per-probe trigger and store decisions
    always_comb begin
        for (int p = 0; p < NPROBE; p++) begin
            logic [15:0] smp;
            smp = probe_data[p*16 +: 16];
            if (pcfg_reg[p][`PCS_PCFG_SRC_BIT]) begin
                trig[p] = sw_trig[p];
            end else begin
                trig[p] = probe_valid[p] &&
                    prev_reg[p] < pcfg_reg[p][`PCS_PCFG_THR_LSB +: 16] &&
                    smp >= pcfg_reg[p][`PCS_PCFG_THR_LSB +: 16];
            end
            trig[p] = trig[p] && armed_reg[p] && ctrl_reg[`PCS_CTRL_SCOPE_BIT];
            // Keep one of N samples, stop at trigger
            store[p] = probe_valid[p] && armed_reg[p] && !trig[p] &&
                ctrl_reg[`PCS_CTRL_SCOPE_BIT] &&
                dcnt_reg[p] == pcs_decim_last(pcfg_reg[p][`PCS_PCFG_TB_LSB +: 4]);
        end
    end

    // Capture memories, one region per probe
    always_ff @(posedge hclk) begin
        for (int p = 0; p < NPROBE; p++) begin
            if (store[p]) begin
                mem[p][wptr_reg[p]] <= probe_data[p*16 +: 16];
            end
        end
    end

    // Write pointers, decimation counters and arm state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NPROBE; p++) begin
                wptr_reg[p] <= '0;
                dcnt_reg[p] <= 15'h0000;
                prev_reg[p] <= 16'h0000;
            end
            armed_reg <= '0;
            probe_frozen <= '0;
        end else begin
            for (int p = 0; p < NPROBE; p++) begin
                if (probe_valid[p]) begin
                    prev_reg[p] <= probe_data[p*16 +: 16];
                end
                if (trig[p]) begin
                    // Trigger wins over a same-cycle re-arm, the re-arm is dropped
                    armed_reg[p] <= 1'b0;
                    probe_frozen[p] <= 1'b1;
                end else if (sw_arm[p]) begin
                    // Re-arm restarts circular recording
                    armed_reg[p] <= 1'b1;
                    probe_frozen[p] <= 1'b0;
                    dcnt_reg[p] <= 15'h0000;
                end else if (probe_valid[p] && armed_reg[p]) begin
                    if (dcnt_reg[p] == pcs_decim_last(pcfg_reg[p][`PCS_PCFG_TB_LSB +: 4])) begin
                        dcnt_reg[p] <= 15'h0000;
                    end else begin
                        dcnt_reg[p] <= dcnt_reg[p] + 15'h0001;
                    end
                end
                if (store[p]) begin
                    wptr_reg[p] <= wptr_reg[p] + 1'b1;
                end
            end
        end
    end

    // Set-up registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `PCS_CTRL_RST;
            rdsel_reg <= `PCS_RDSEL_RST;
            cmd_reg <= 32'h0000_0000;
            for (int p = 0; p < NPROBE; p++) begin
                pcfg_reg[p] <= `PCS_PCFG_RST;
            end
        end else if (wr_now) begin
            if (waddr_reg == `PCS_CTRL_OFS) begin
                ctrl_reg <= hwdata;
            end
            if (waddr_reg == `PCS_CMD_OFS) begin
                cmd_reg <= hwdata;
            end
            if (waddr_reg == `PCS_RDSEL_OFS) begin
                rdsel_reg <= hwdata;
            end
            for (int p = 0; p < NPROBE; p++) begin
                if (waddr_reg == 8'(`PCS_PCFG0_OFS + 4*p)) begin
                    pcfg_reg[p] <= hwdata;
                end
            end
        end
    end

    // Readout engine, oldest word first, stalled by the FIFO
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ro_state_reg <= PCS_RO_IDLE;
            ro_sel_reg <= 2'b00;
            ro_addr_reg <= '0;
            ro_left_reg <= '0;
            ro_vld_reg <= 1'b0;
            ro_word_reg <= 16'h0000;
        end else begin
            if (ro_vld_reg && f_in_ready) begin
                ro_vld_reg <= 1'b0;
            end
            case (ro_state_reg)
                PCS_RO_IDLE: begin
                    if (ro_start && probe_frozen[hwdata[1:0]]) begin
                        ro_sel_reg <= hwdata[1:0];
                        ro_addr_reg <= wptr_reg[hwdata[1:0]];
                        ro_left_reg <= (AW+1)'(DEPTH);
                        ro_state_reg <= PCS_RO_RUN;
                    end
                end
                PCS_RO_RUN: begin
                    if (ro_left_reg == '0) begin
                        ro_state_reg <= PCS_RO_IDLE;
                    end else if (!ro_vld_reg || f_in_ready) begin
                        ro_word_reg <= mem[ro_sel_reg][ro_addr_reg];
                        ro_vld_reg <= 1'b1;
                        ro_addr_reg <= ro_addr_reg + 1'b1;
                        ro_left_reg <= ro_left_reg - 1'b1;
                    end
                end
                default: ro_state_reg <= PCS_RO_IDLE;
            endcase
        end
    end

    pcs_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .clr(ro_start),
        .s_data(ro_word_reg),
        .s_valid(ro_vld_reg),
        .s_ready(f_in_ready),
        .m_data(f_out_data),
        .m_valid(f_out_valid),
        .m_ready(data_pop)
    );

    // AHB-Lite phase tracking; reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            waddr_reg <= 8'h00;
            raddr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hresp <= 1'b0;
            if (rd_pend_reg) begin
                hreadyout <= 1'b1;
            end else if (hsel && hready && htrans[1]) begin
                if (hwrite) begin
                    wr_pend_reg <= 1'b1;
                    waddr_reg <= haddr[7:0];
                end else begin
                    rd_pend_reg <= 1'b1;
                    raddr_reg <= haddr[7:0];
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // Read data mux, unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata <= 32'h0000_0000;
            case (raddr_reg)
                `PCS_CTRL_OFS: hrdata <= ctrl_reg;
                `PCS_CMD_OFS: hrdata <= cmd_reg;
                `PCS_RDSEL_OFS: hrdata <= rdsel_reg;
                `PCS_STAT_OFS: begin
                    hrdata[NPROBE-1:0] <= probe_frozen;
                    hrdata[`PCS_STAT_BUSY_BIT] <= (ro_state_reg == PCS_RO_RUN);
                end
                `PCS_DATA_OFS: begin
                    hrdata[15:0] <= f_out_valid ? f_out_data : 16'h0000;
                    hrdata[`PCS_DATA_VALID_BIT] <= f_out_valid;
                end
                default: begin
                    for (int p = 0; p < NPROBE; p++) begin
                        if (raddr_reg == 8'(`PCS_PCFG0_OFS + 4*p)) begin
                            hrdata <= pcfg_reg[p];
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== pkg/pcs_regs.svh
/*
 * Register map and field layout of the probe capture scope.
 * Assumes byte addressing on a 32-bit bus, one word per register.
 */
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define PCS_CTRL_OFS 8'h00
`define PCS_CMD_OFS 8'h04
`define PCS_STAT_OFS 8'h08
`define PCS_RDSEL_OFS 8'h0c
`define PCS_PCFG0_OFS 8'h10
`define PCS_DATA_OFS 8'h20

// ****************************************
// Fields
// ****************************************
`define PCS_CTRL_SCOPE_BIT 0
`define PCS_CMD_TRIG_LSB 0
`define PCS_CMD_ARM_LSB 4
`define PCS_RDSEL_START_BIT 8
`define PCS_PCFG_TB_LSB 0
`define PCS_PCFG_SRC_BIT 4
`define PCS_PCFG_THR_LSB 16
`define PCS_DATA_VALID_BIT 16
`define PCS_STAT_BUSY_BIT 8

// ****************************************
// Reset values
// ****************************************
`define PCS_CTRL_RST 32'h0000_0000
`define PCS_PCFG_RST 32'h0000_0000
`define PCS_RDSEL_RST 32'h0000_0000

`endif

// ===== pkg/pcs_pkg.sv
/*
 * Types and shared helpers of the probe capture scope.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pcs_pkg;
    // Readout engine states
    typedef enum logic {PCS_RO_IDLE, PCS_RO_RUN} pcs_ro_e;

    // Last value of the decimation counter for a time-base code
    function automatic logic [14:0] pcs_decim_last(input logic [3:0] tb);
        logic [15:0] n;
        n = 16'h0001 << tb;
        return 15'(n - 16'h0001);
    endfunction
endpackage

// ===== verif/pcs_probe_src.sv
/*
 * Probe source model: one ramp shared by all probes, optional gaps.
 * Assumes the capture block's clock; restart zeroes the ramp.
 */
`timescale 1ns/1ps
`default_nettype none
// ********
// Source
// ********
module pcs_probe_src #(
    parameter int NPROBE = 4
) (
    input wire logic clk,
    input wire logic restart,
    input wire logic gap,
    output logic [NPROBE*16-1:0] data,
    output logic [NPROBE-1:0] valid
);
    logic [15:0] cnt = 16'h0000;
    logic ph = 1'b0;
    // Ramp steps once per word handed over
    always_ff @(posedge clk) begin
        ph <= ~ph;
        if (restart)
            cnt <= 16'h0000;
        else if (!gap || ph)
            cnt <= cnt + 16'h0001;
    end
    // Idle cycles carry the inverse word
    always_comb begin
        valid = {NPROBE{!restart && (!gap || ph)}};
        for (int p = 0; p < NPROBE; p++)
            data[p*16+:16] = valid[p] ? cnt : ~cnt;
    end
endmodule
`default_nettype wire

// ===== verif/pcs_top_chk.sv
/*
 * Port checker of the capture block, bound to its top.
 * Assumes hready driven from hreadyout and one master.
 */
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module pcs_chk #(
    parameter int NPROBE = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NPROBE-1:0] probe_valid,
    input wire logic [NPROBE-1:0] probe_frozen
);
    logic [2:0] wcnt;
    logic rst_seen = 1'b0;
    // First edge lets the design's reset branch run before checking it
    always_ff @(posedge hclk)
        rst_seen <= 1'b1;
    wire logic take = hsel && hready && htrans[1];
    // Cycles since the last write was taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wcnt <= 3'h7;
        else if (take && hwrite)
            wcnt <= 3'h0;
        else if (wcnt != 3'h7)
            wcnt <= wcnt + 3'h1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_resp;
        hresp == 1'b0;
    endproperty
    a_resp: assert property (p_resp) else $error("error response");
    property p_wr;
        take && hwrite |=> hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_rd;
        take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait wrong");
    property p_low;
        !hreadyout |=> hreadyout;
    endproperty
    a_low: assert property (p_low) else $error("long wait");
    property p_hold;
        $changed(hrdata) |-> $rose(hreadyout);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_fall;
        $fell(probe_frozen[0]) |-> wcnt <= 3'h3;
    endproperty
    a_fall: assert property (p_fall) else $error("unfroze unasked");
    property p_rose;
        $rose(probe_frozen[0]) |-> wcnt <= 3'h3 || $past(probe_valid[0]);
    endproperty
    a_rose: assert property (p_rose) else $error("froze uncaused");
    property p_rst;
        disable iff (1'b0) !hresetn && rst_seen |-> hreadyout && !hresp && probe_frozen == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    c_rd: cover property (take && !hwrite);
    c_frz: cover property ($rose(probe_frozen[0]));
    c_arm: cover property ($fell(probe_frozen[0]));
endmodule
bind pcs_top pcs_chk #(.NPROBE(NPROBE)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .probe_valid(probe_valid),
    .probe_frozen(probe_frozen));
`default_nettype wire

// ===== verif/probe_capture_scope_tb.sv
/*
 * Testbench of the capture block: AHB-Lite master tasks and scenarios.
 * Assumes the ramp source model and a 16-word buffer depth.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
// ********
// Bench
// ********
module probe_capture_scope_tb;
    localparam int DEPTH = 16;
    logic hclk;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic restart = 1'b1;
    logic gap = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [63:0] probe_data;
    logic [3:0] probe_valid;
    logic [3:0] probe_frozen;
    int fails = 0;
    int checks_done = 0;
    pcs_top #(.NPROBE(4), .DEPTH(DEPTH), .FIFO_DEPTH(16)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .probe_data(probe_data), .probe_valid(probe_valid),
        .probe_frozen(probe_frozen));
    pcs_probe_src #(.NPROBE(4)) src (.clk(hclk), .restart(restart), .gap(gap),
        .data(probe_data), .valid(probe_valid));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Wait for hready high at a rising edge, taking read data there
    task automatic wait_rdy(output logic [31:0] d);
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        d = hrdata;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0000_0000, d);
    endtask
    task automatic wait_frz(input logic [3:0] m);
        for (int k = 0; k < 1000 && probe_frozen !== m; k++)
            @(posedge hclk);
        chk(32'(probe_frozen), 32'(m));
    endtask
    // Read one frozen buffer out and check spacing of stored words
    task automatic ro(input int p, input logic [15:0] step, input logic [15:0] last);
        logic [31:0] d;
        logic [15:0] prev;
        prev = 16'h0000;
        wr(`PCS_RDSEL_OFS, 32'h0000_0100 | 32'(p));
        for (int i = 0; i < DEPTH; i++) begin
            d = 32'h0000_0000;
            for (int k = 0; k < 50 && !d[16]; k++)
                rd(`PCS_DATA_OFS, d);
            chk(32'(d[16]), 32'h0000_0001);
            if (i > 0)
                chk(32'(16'(d[15:0] - prev)), 32'(step));
            prev = d[15:0];
        end
        if (last != 16'h0000)
            chk(32'(prev), 32'(last));
    endtask
    task automatic t_regs;
        logic [31:0] d;
        rd(`PCS_CTRL_OFS, d);
        chk(d, `PCS_CTRL_RST);
        rd(`PCS_RDSEL_OFS, d);
        chk(d, `PCS_RDSEL_RST);
        for (int i = 0; i < 4; i++) begin
            rd(8'(`PCS_PCFG0_OFS + 4 * i), d);
            chk(d, `PCS_PCFG_RST);
            wr(8'(`PCS_PCFG0_OFS + 4 * i), 32'hA5C3_0010 + 32'(i));
            rd(8'(`PCS_PCFG0_OFS + 4 * i), d);
            chk(d, 32'hA5C3_0010 + 32'(i));
        end
        wr(`PCS_CMD_OFS, 32'h0000_A500);
        rd(`PCS_CMD_OFS, d);
        chk(d, 32'h0000_A500);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, d);
        chk(d, 32'h0000_0000);
    endtask
    task automatic t_param;
        restart <= 1'b0;
        wr(`PCS_PCFG0_OFS, 32'h0000_0010);
        wr(`PCS_CMD_OFS, 32'h0000_0010);
        wr(`PCS_CMD_OFS, 32'h0000_0001);
        repeat (8) @(posedge hclk);
        chk(32'(probe_frozen), 32'h0000_0000);
    endtask
    task automatic t_decim;
        logic [31:0] d;
        wr(`PCS_CTRL_OFS, 32'h0000_0001);
        rd(`PCS_CTRL_OFS, d);
        chk(d, 32'h0000_0001);
        for (int p = 0; p < 4; p++)
            wr(8'(`PCS_PCFG0_OFS + 4 * p), 32'h0000_0010 | 32'(p));
        wr(`PCS_CMD_OFS, 32'h0000_00F0);
        repeat (200) @(posedge hclk);
        wr(`PCS_CMD_OFS, 32'h0000_000F);
        wait_frz(4'hF);
        rd(`PCS_STAT_OFS, d);
        chk(d & 32'h0000_000F, 32'h0000_000F);
        for (int p = 0; p < 4; p++)
            ro(p, 16'(1 << p), 16'h0000);
    endtask
    task automatic t_thresh;
        restart <= 1'b1;
        gap <= 1'b1;
        wr(`PCS_PCFG0_OFS, 32'h0080_0000);
        wr(`PCS_CMD_OFS, 32'h0000_0010);
        wait_frz(4'hE);
        restart <= 1'b0;
        wait_frz(4'hF);
        ro(0, 16'h0001, 16'h007F);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_param;
        t_decim;
        t_thresh;
        results;
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge hclk);
        fails++;
        results;
    end
endmodule
`default_nettype wire
